/* hdl/dma_chan_pkg.sv */
// constants, encodings and carrier types for the dma channel status slice
// assumes a single pclk domain and an apb register port with 32-bit data
package dma_chan_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int CHAN_COUNT = 8; // plain default channel count
  localparam int CHAN_SEL_W = 3;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CHAN_SELECT = 10'h03F;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h040;
  localparam logic [IDX_W-1:0] IDX_ENABLE_CLEAR = 10'h04C;
  localparam logic [IDX_W-1:0] IDX_ENABLE_SET = 10'h04D;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 10'h04E;
  localparam logic [IDX_W-1:0] IDX_CHAN_STATE = 10'h04F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h050;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h051;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // enable and flag layout
  localparam int BIT_HALT = 2;
  localparam int BIT_DONE = 1;
  localparam int BIT_ERR = 0;
  // state layout
  localparam int BIT_FETCH_ERR = 2;
  localparam int BIT_BUSY = 1;
  localparam int BIT_WAIT = 0;
  // channel_control_b layout
  localparam int CTRL_ACT_LSB = 0;
  localparam int CTRL_EVENT_IN_ENABLE = 3;
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_CMD_HALT = 5;
  localparam int CTRL_CMD_RESUME = 6;
  // block_end_action layout
  localparam int BLKACT_IRQ_BIT = 0;
  localparam int BLKACT_HALT_BIT = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] ENABLE_RST = 3'h0;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [2:0] STATE_RST = 3'h0;
  localparam logic [2:0] ACTION_RST = 3'h0;
  localparam logic [CHAN_SEL_W-1:0] SELECT_RST = 3'h0;
  localparam logic [CHAN_COUNT-1:0] IRQ_RST = 8'h00;

  // event input action encodings
  typedef enum logic [2:0] {
    no_action_code = 3'h0,
    normal_event_start = 3'h1,
    conditional_beat_event = 3'h2,
    conditional_block_event = 3'h3,
    halt_action = 3'h4,
    resume_action = 3'h5,
    skip_next_suspend = 3'h6,
    reserved_action = 3'h7
  } event_in_action_t;

  // per-channel happenings reported by the transfer engine
  typedef struct packed {
    logic event_in;              // incoming channel event strobe
    logic request;               // transfer request received
    logic normal_event_start_start;            // trigger action started
    logic normal_event_start_done;             // trigger action completed
    logic xfer_start;            // channel starts a transfer
    logic block_done;            // block transfer finished
    logic [1:0] block_end_action; // action of the finished block
    logic bus_error;             // bus error on a beat
    logic desc_invalid;          // invalid descriptor fetched
  } engine_evt_t;

  // per-channel orders back to the transfer engine
  typedef struct packed {
    logic normal_start;
    logic cond_beat;
    logic cond_block;
    logic halt;
    logic resume;
    logic skip_suspend;
  } chan_action_t;

endpackage

/* hdl/dma_channel_status_irq.sv */
// per-channel control, interrupt enable, flag and state slice of a dma controller
// assumes engine strobes are one-cycle pulses synchronous to pclk, apb on the same clock
//
// Summary of operation
// R1: event codes 0-3: none, start, beat, block
// R2: codes 4-6 halt, resume, skip; 7 reserved
// R3: event actions run only with input enabled
// R4: enable clear register: ones clear enables
// R5: enable set register: ones set enables
// R6: both registers share and read one enable set
// R7: channel register accesses reach only the selected channel
// R8: halt flag on block with halt action, command, halt event, bad descriptor
// R9: flags clear by writing one
// R10: done flag on block with interrupt action
// R11: no done flag when block action none
// R12: error flag on bus error or bad descriptor
// R13: fetch error set by bad descriptor, resume command clears
// R14: busy set on start, cleared on done/error/disable
// R15: waiting set on request, cleared start/error/disable
// R16: channel request when flag and enable both set
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps

module dma_channel_status_irq
  import dma_chan_pkg::*;
(
  input wire logic pclk, // controller clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [dma_chan_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input dma_chan_pkg::engine_evt_t engine_evt [dma_chan_pkg::CHAN_COUNT], // engine strobes
  output dma_chan_pkg::chan_action_t chan_action [dma_chan_pkg::CHAN_COUNT], // action pulses
  output logic [dma_chan_pkg::CHAN_COUNT-1:0] chan_enable, // channel enable levels
  output logic [dma_chan_pkg::CHAN_COUNT-1:0] chan_irq_req, // per-channel requests
  output logic irq // combined interrupt level
);
  import dma_chan_pkg::*;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic setup_phase;
  logic wr_access;
  logic rd_access;
  logic mapped;
  logic [31:0] rd_word;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [CHAN_SEL_W-1:0] select_reg;
  logic [CHAN_COUNT-1:0] irq_status_reg;
  logic [CHAN_COUNT-1:0] irq_status_next;
  logic [CHAN_COUNT-1:0] irq_mask_reg;
  logic [CHAN_COUNT-1:0] irq_snap_reg;
  logic [CHAN_COUNT-1:0] chan_irq_d_reg;
  logic [2:0] enable_vec [CHAN_COUNT];
  logic [2:0] flags_vec [CHAN_COUNT];
  logic [2:0] state_vec [CHAN_COUNT];
  logic [4:0] ctrl_vec [CHAN_COUNT];

  // access phases; writes land at the access edge only
  assign idx = paddr[ADDR_W-1:2];
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite & mapped;
  assign rd_access = psel & penable & ~pwrite;

  // zero wait state slave
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // address map and read mux, channel registers of the selected channel only
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (idx)
      IDX_CHAN_SELECT: rd_word[CHAN_SEL_W-1:0] = select_reg;
      IDX_CTRL_B: rd_word[4:0] = ctrl_vec[select_reg]; // R7
      IDX_ENABLE_CLEAR: rd_word[2:0] = enable_vec[select_reg]; // R6
      IDX_ENABLE_SET: rd_word[2:0] = enable_vec[select_reg]; // R6
      IDX_IRQ_FLAGS: rd_word[2:0] = flags_vec[select_reg]; // R7
      IDX_CHAN_STATE: rd_word[2:0] = state_vec[select_reg]; // R7
      IDX_IRQ_STATUS: rd_word[CHAN_COUNT-1:0] = irq_status_reg;
      IDX_IRQ_MASK: rd_word[CHAN_COUNT-1:0] = irq_mask_reg;
      default: mapped = 1'b0;
    endcase
  end

  // read data and error are captured in setup so they come from flops in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_reg <= ~mapped;
    end
  end

  // channel select pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= SELECT_RST;
    end else if (wr_access && idx == IDX_CHAN_SELECT) begin
      select_reg <= pwdata[CHAN_SEL_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // per-channel logic
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < CHAN_COUNT; c++) begin : g_chan
      logic hit;
      logic wr_ctrl;
      logic sw_halt;
      logic sw_resume;
      logic fire;
      logic [2:0] action_code;
      logic [2:0] enable_reg;
      logic [2:0] flags_reg;
      logic [2:0] flag_set;
      logic [2:0] flag_clr;
      logic [2:0] action_reg;
      logic event_in_enable_reg;
      logic chan_en_reg;
      logic fetch_err_reg;
      logic busy_reg;
      logic wait_reg;
      chan_action_t act_reg;

      assign hit = (select_reg == CHAN_SEL_W'(c)); // R7
      assign wr_ctrl = wr_access & hit & (idx == IDX_CTRL_B);
      assign sw_halt = wr_ctrl & pwdata[CTRL_CMD_HALT];
      assign sw_resume = wr_ctrl & pwdata[CTRL_CMD_RESUME];
      assign fire = engine_evt[c].event_in & event_in_enable_reg; // R3
      assign action_code = action_reg;

      // control bits; command bits are pulses and are not stored
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          action_reg <= ACTION_RST;
          event_in_enable_reg <= 1'b0;
          chan_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
          action_reg <= pwdata[CTRL_ACT_LSB +: 3];
          event_in_enable_reg <= pwdata[CTRL_EVENT_IN_ENABLE];
          chan_en_reg <= pwdata[CTRL_ENABLE];
        end
      end

      // decoded event actions, one-cycle pulses; 0x0 and 0x7 do nothing
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_reg <= '0;
        end else begin
          act_reg.normal_start <= fire && action_code == normal_event_start; // R1
          act_reg.cond_beat <= fire && action_code == conditional_beat_event; // R1
          act_reg.cond_block <= fire && action_code == conditional_block_event; // R1
          act_reg.halt <= (fire && action_code == halt_action) || sw_halt; // R2
          act_reg.resume <= (fire && action_code == resume_action) || sw_resume; // R2
          act_reg.skip_suspend <= fire && action_code == skip_next_suspend; // R2
        end
      end

      // shared enable bits behind the clear and set registers
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enable_reg <= ENABLE_RST;
        end else if (wr_access && hit && idx == IDX_ENABLE_CLEAR) begin
          enable_reg <= enable_reg & ~pwdata[2:0]; // R4
        end else if (wr_access && hit && idx == IDX_ENABLE_SET) begin
          enable_reg <= enable_reg | pwdata[2:0]; // R5
        end
      end

      // flag sources; a set in the clearing cycle wins
      always_comb begin
        flag_set = 3'h0;
        flag_set[BIT_HALT] = (engine_evt[c].block_done &
                              engine_evt[c].block_end_action[BLKACT_HALT_BIT]) |
                             sw_halt | (fire && action_code == halt_action) |
                             engine_evt[c].desc_invalid; // R8
        flag_set[BIT_DONE] = engine_evt[c].block_done &
                             engine_evt[c].block_end_action[BLKACT_IRQ_BIT]; // R10 R11
        flag_set[BIT_ERR] = engine_evt[c].bus_error | engine_evt[c].desc_invalid; // R12
        flag_clr = (wr_access && hit && idx == IDX_IRQ_FLAGS) ? pwdata[2:0] : 3'h0;
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_reg <= FLAGS_RST;
        end else begin
          flags_reg <= (flags_reg & ~flag_clr) | flag_set; // R9
        end
      end

      // fetch error: only a software resume clears it
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fetch_err_reg <= 1'b0;
        end else if (engine_evt[c].desc_invalid) begin
          fetch_err_reg <= 1'b1; // R13
        end else if (sw_resume) begin
          fetch_err_reg <= 1'b0; // R13
        end
      end

      // busy; disabling the channel overrides a start in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          busy_reg <= 1'b0;
        end else if (!chan_en_reg) begin
          busy_reg <= 1'b0; // R14
        end else if (engine_evt[c].xfer_start) begin
          busy_reg <= 1'b1; // R14
        end else if (engine_evt[c].normal_event_start_done || engine_evt[c].bus_error) begin
          busy_reg <= 1'b0; // R14
        end
      end

      // waiting; a fresh request beats a start of the previous one
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wait_reg <= 1'b0;
        end else if (!chan_en_reg) begin
          wait_reg <= 1'b0; // R15
        end else if (engine_evt[c].request) begin
          wait_reg <= 1'b1; // R15
        end else if (engine_evt[c].normal_event_start_start || engine_evt[c].bus_error) begin
          wait_reg <= 1'b0; // R15
        end
      end

      // publish to the read mux and the ports
      assign enable_vec[c] = enable_reg;
      assign flags_vec[c] = flags_reg;
      assign state_vec[c] = {fetch_err_reg, busy_reg, wait_reg};
      assign ctrl_vec[c] = {chan_en_reg, event_in_enable_reg, action_reg};
      assign chan_action[c] = act_reg;
      assign chan_enable[c] = chan_en_reg;
      assign chan_irq_req[c] = |(flags_reg & enable_reg); // R16
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt collection
  // ---------------------------------------------------------------
  // snapshot the bits a status read returns so only those are cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_snap_reg <= IRQ_RST;
    end else if (setup_phase) begin
      irq_snap_reg <= (!pwrite && idx == IDX_IRQ_STATUS) ? irq_status_reg : IRQ_RST;
    end
  end

  // sticky status: rising channel request sets, read clears, set wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_access && idx == IDX_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~irq_snap_reg;
    end
    irq_status_next = irq_status_next | (chan_irq_req & ~chan_irq_d_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= IRQ_RST;
      chan_irq_d_reg <= IRQ_RST;
    end else begin
      irq_status_reg <= irq_status_next;
      chan_irq_d_reg <= chan_irq_req;
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= IRQ_RST;
    end else if (wr_access && idx == IDX_IRQ_MASK) begin
      irq_mask_reg <= pwdata[CHAN_COUNT-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

/* sim/dma_chan_status_monitor.sv */
// checker for the dma channel status slice, bound to its top ports
// assumes one pclk domain and register index = paddr[11:2]
`timescale 1ns/100ps
module dma_chan_status_monitor
  import dma_chan_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input engine_evt_t engine_evt [CHAN_COUNT], // strobes
  input chan_action_t chan_action [CHAN_COUNT], // pulses
  input wire logic [CHAN_COUNT-1:0] chan_enable, // enables
  input wire logic [CHAN_COUNT-1:0] chan_irq_req, // requests
  input wire logic irq // interrupt
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  wire [IDX_W-1:0] idx = paddr[11:2];
  wire wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // per-channel relations
  // ----------------------------------------
  for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_ch
    ev_act_a: assert property (
      chan_action[c].normal_start || chan_action[c].cond_beat || chan_action[c].cond_block
      || chan_action[c].skip_suspend |-> $past(engine_evt[c].event_in))
      else $error("action pulse without event");
    act_onehot_a: assert property (
      $onehot0({chan_action[c].normal_start, chan_action[c].cond_beat,
      chan_action[c].cond_block, chan_action[c].skip_suspend}))
      else $error("two event actions at once");
    halt_cause_a: assert property (
      chan_action[c].halt || chan_action[c].resume
      |-> $past(engine_evt[c].event_in || (wr && idx == IDX_CTRL_B)))
      else $error("halt or resume without cause");
    en_change_a: assert property (
      $changed(chan_enable[c]) |-> $past(wr && idx == IDX_CTRL_B))
      else $error("enable moved without control write");
    req_rise_a: assert property (
      $rose(chan_irq_req[c]) |-> $past(engine_evt[c].event_in || engine_evt[c].block_done
      || engine_evt[c].bus_error || engine_evt[c].desc_invalid
      || (wr && (idx == IDX_ENABLE_SET || idx == IDX_CTRL_B))))
      else $error("request rose without cause");
    req_fall_a: assert property (
      $fell(chan_irq_req[c])
      |-> $past(wr && (idx == IDX_ENABLE_CLEAR || idx == IDX_IRQ_FLAGS)))
      else $error("request fell without clearing write");
  end

  // ----------------------------------------
  // combined interrupt
  // ----------------------------------------
  irq_rise_a: assert property (
    $rose(irq) |-> $past(|chan_irq_req) || $past(wr && idx == IDX_IRQ_MASK))
    else $error("irq rose without request");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(psel && (idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK)))
    else $error("irq fell without status read");
  cover property (chan_action[3].halt);
  cover property ($rose(irq));
  cover property ($fell(chan_irq_req[3]));
endmodule

/* sim/tb.sv */
// self-checking bench for the dma channel status slice
// assumes zero-wait apb and one-cycle engine strobes on pclk
`timescale 1ns/100ps
module tb;
  import dma_chan_pkg::*;
  // strobe bits of the packed engine struct
  localparam logic [9:0] E_IN = 10'h200, E_REQ = 10'h100, E_TS = 10'h080;
  localparam logic [9:0] E_TD = 10'h040, E_XS = 10'h020, E_BD = 10'h010;
  localparam logic [9:0] E_BE = 10'h002, E_DI = 10'h001;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  engine_evt_t ev [CHAN_COUNT];
  chan_action_t act [CHAN_COUNT];
  logic [CHAN_COUNT-1:0] chen, ireq;
  logic [2:0] en_m, msk;
  int err_total, total_checks, ch;
  logic [9:0] ss [6] = '{E_REQ, E_TS, E_XS, E_TD, E_REQ | E_XS, E_BE};
  logic [31:0] se [6] = '{32'h1, 32'h0, 32'h2, 32'h0, 32'h3, 32'h0};

  dma_channel_status_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_evt(ev),
    .chan_action(act), .chan_enable(chen), .chan_irq_req(ireq), .irq(irq));

  // ----------------------------------------
  // bus, strobe and compare tasks
  // ----------------------------------------
  task automatic apb(input logic [IDX_W-1:0] idx, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    chk(rd_val, exp);
  endtask
  // one-cycle strobe; returns just after the edge that takes it
  task automatic pulse(input logic [9:0] v);
    @(posedge pclk);
    ev[ch] <= engine_evt_t'(v);
    @(posedge pclk);
    ev[ch] <= '0;
    #1;
  endtask
  function automatic logic [5:0] act_exp(input int code);
    logic [5:0] a;
    a = 6'h00;
    if (code >= 1 && code <= 6) a[6-code] = 1'b1;
    return a;
  endfunction
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    $display("ERROR %0t watchdog expired", $time);
    err_total++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    foreach (ev[i]) ev[i] = '0;
    ch = 0;
    rd_val = $urandom(32'h9f80);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(IDX_W'(IDX_ENABLE_CLEAR + i), 32'h0);
    apb(10'h3FF, 1'b0, 32'h0);
    chk({31'h0, pslverr}, 32'h1);
    // shared enables, isolated per channel
    repeat (4) begin
      ch = $urandom_range(7);
      en_m = 3'($urandom);
      msk = 3'($urandom);
      apb(IDX_CHAN_SELECT, 1'b1, ch);
      apb(IDX_ENABLE_CLEAR, 1'b1, 32'h7);
      apb(IDX_ENABLE_SET, 1'b1, {29'h0, en_m});
      apb(IDX_CHAN_SELECT, 1'b1, ch ^ 1);
      apb(IDX_ENABLE_CLEAR, 1'b1, 32'h7);
      apb(IDX_CHAN_SELECT, 1'b1, ch);
      rdchk(IDX_ENABLE_CLEAR, {29'h0, en_m});
      apb(IDX_ENABLE_CLEAR, 1'b1, {29'h0, msk});
      rdchk(IDX_ENABLE_SET, {29'h0, en_m & ~msk});
    end
    ch = 3;
    apb(IDX_CHAN_SELECT, 1'b1, 32'h3);
    apb(IDX_ENABLE_CLEAR, 1'b1, 32'h7);
    // every event code, input enabled then disabled
    for (int k = 0; k < 8; k++) begin
      apb(IDX_CTRL_B, 1'b1, 32'h18 | k);
      #1;
      chk({24'h0, chen}, 32'h8);
      pulse(E_IN);
      chk({26'h0, act[3]}, {26'h0, act_exp(k)});
      apb(IDX_CTRL_B, 1'b1, 32'h10 | k);
      pulse(E_IN);
      chk({26'h0, act[3]}, 32'h0);
    end
    rdchk(IDX_IRQ_FLAGS, 32'h4);
    apb(IDX_IRQ_FLAGS, 1'b1, 32'h0);
    rdchk(IDX_IRQ_FLAGS, 32'h4);
    apb(IDX_IRQ_FLAGS, 1'b1, 32'h4);
    rdchk(IDX_IRQ_FLAGS, 32'h0);
    for (int b = 0; b < 4; b++) begin
      pulse(E_BD | 10'(b << 2));
      rdchk(IDX_IRQ_FLAGS, {29'h0, b[1], b[0], 1'b0});
      apb(IDX_IRQ_FLAGS, 1'b1, 32'h7);
    end
    pulse(E_BE);
    rdchk(IDX_IRQ_FLAGS, 32'h1);
    pulse(E_DI);
    rdchk(IDX_IRQ_FLAGS, 32'h5);
    apb(IDX_IRQ_FLAGS, 1'b1, 32'h7);
    rdchk(IDX_CHAN_STATE, 32'h4);
    apb(IDX_CTRL_B, 1'b1, 32'h50);
    rdchk(IDX_CHAN_STATE, 32'h0);
    foreach (ss[i]) begin
      pulse(ss[i]);
      rdchk(IDX_CHAN_STATE, se[i]);
    end
    pulse(E_REQ | E_XS);
    apb(IDX_CTRL_B, 1'b1, 32'h0);
    #1;
    chk({24'h0, chen}, 32'h0);
    rdchk(IDX_CHAN_STATE, 32'h0);
    // interrupt raised, read-cleared, then masked
    apb(IDX_IRQ_FLAGS, 1'b1, 32'h7);
    apb(IDX_ENABLE_SET, 1'b1, 32'h1);
    apb(IDX_IRQ_MASK, 1'b1, 32'h8);
    pulse(E_BE);
    chk({24'h0, ireq}, 32'h8);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    rdchk(IDX_IRQ_STATUS, 32'h8);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(IDX_IRQ_FLAGS, 1'b1, 32'h1);
    #1;
    chk({24'h0, ireq}, 32'h0);
    apb(IDX_IRQ_MASK, 1'b1, 32'h0);
    pulse(E_BE);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rdchk(IDX_IRQ_STATUS, 32'h8);
    end_sim();
  end
endmodule

bind dma_channel_status_irq dma_chan_status_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_evt(engine_evt),
  .chan_action(chan_action), .chan_enable(chan_enable), .chan_irq_req(chan_irq_req),
  .irq(irq));
